// *** inc/fsr_pkg.sv ***
// Constants shared by both ends of the security-register and ID link.
// Assumes a 40 MHz system clock on both ends and SPI mode 0 on the link.
`default_nettype none
package fsr_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_UNIQUE_ID     = 8'h4b;
  localparam logic [7:0] OP_DEVICE_ID     = 8'h9f;
  localparam logic [7:0] OP_PARAM_TABLE   = 8'h5a;
  localparam logic [7:0] OP_SEC_ERASE     = 8'h44;
  localparam logic [7:0] OP_SEC_PROGRAM   = 8'h42;
  localparam logic [7:0] OP_SEC_READ      = 8'h48;
  // Frame layout, in link clocks
  localparam logic [15:0] OPCODE_BITS     = 16'h0008;
  localparam logic [15:0] ADDR3_BITS      = 16'h0018;
  localparam logic [15:0] ADDR4_BITS      = 16'h0020;
  localparam logic [15:0] DUMMY_BITS      = 16'h0008;
  localparam logic [15:0] UID_DUMMY3_BITS = 16'h0020;
  localparam logic [15:0] UID_DUMMY4_BITS = 16'h0028;
  localparam logic [15:0] TABLE_START     = 16'h0028;
  localparam logic [15:0] NO_DATA         = 16'hffff;
  // Status byte fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT  = 1;
  // Security register select field
  localparam logic [3:0] SEC_SEL_FIRST = 4'h1;
  localparam logic [3:0] SEC_SEL_LAST  = 4'h3;
  localparam logic [7:0] ERASED_BYTE   = 8'hff;
  // Internal cycle lengths (system clocks); erase sweeps 256 bytes first
  localparam int SEC_ERASE_CYCLES_DEFAULT = 1024;
  localparam int SEC_PROG_CYCLES_DEFAULT  = 64;
  // Host register map (APB byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_DATA   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_CS_BIT  = 0;
  localparam int CTRL_DIV_LSB = 8;
  localparam logic [7:0] HALF_PERIOD_RESET = 8'h08;
  localparam logic [7:0] HALF_PERIOD_MIN   = 8'h06;
  typedef enum logic [1:0] {
    FSR_IDLE = 2'b00,
    FSR_LOW  = 2'b01,
    FSR_HIGH = 2'b10
  } fsr_link_state_t;
endpackage
`default_nettype wire

// *** inc/fsr_spi_if.sv ***
// Serial link between the host controller and the flash device end.
// The bench instantiates it; the data-out wire idles high when undriven.
`default_nettype none
interface fsr_spi_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev  (input cs_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso_line);
endinterface
`default_nettype wire

// *** verilog/fsr_device.sv ***
// Device end: ID reads, parameter table and three security registers.
// Assumes the link pins arrive asynchronously; all are sampled twice.
//
// The register addresses and the APB interface to the registers were decided locally.
`default_nettype none
module fsr_device
  import fsr_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID      = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter logic [7:0]  MAKER_BYTE     = 8'h5c,                   // Arbitrary value
  parameter logic [7:0]  MEMORY_TYPE    = 8'h40,
  parameter logic [7:0]  CAPACITY_BYTE  = 8'h20,
  parameter int          ERASE_CYCLES   = SEC_ERASE_CYCLES_DEFAULT,
  parameter int          PROGRAM_CYCLES = SEC_PROG_CYCLES_DEFAULT
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire logic       i_clock_en,
  // Link
  fsr_spi_if.dev          spi,
  // User side
  input  wire logic       i_four_byte_mode,
  input  wire logic [2:0] i_security_lock_bits,
  output logic            o_busy,
  output logic            o_write_enable_latch
);
  logic        cs_q1, cs_q2, cs_q3, sck_q1, sck_q2, sck_q3, si_q1, si_q2;
  logic        sck_rise, sck_fall, cs_rise;
  logic [15:0] bitcnt;
  logic [31:0] shifter;
  logic [7:0]  opcode;
  logic [31:0] addr;
  logic        cmd_ok;
  logic [7:0]  out_sr;
  logic [7:0]  byte_idx;
  logic [7:0]  prog_ptr;
  logic        prog_wrote;
  logic        erasing;
  logic [1:0]  target;
  logic [31:0] cycle_cnt;
  logic [7:0]  sec_mem [0:767];
  logic [15:0] addr_end, data_start;
  logic [31:0] next_addr;
  logic [7:0]  next_byte;
  logic [1:0]  sel_idx;
  logic        sel_ok, wr_byte, erase_go;

  function automatic logic sec_valid(input logic [31:0] a, input logic [2:0] locks);
    logic [3:0] s;
    s = a[15:12];
    sec_valid = (a[31:16] == 16'h0000) && (a[11:8] == 4'h0)
             && (s >= SEC_SEL_FIRST) && (s <= SEC_SEL_LAST)
             && !locks[s[1:0] - 2'd1];
  endfunction

  function automatic logic [7:0] table_byte(input logic [7:0] idx);
    case (idx)
      8'h00:   table_byte = 8'h53;
      8'h01:   table_byte = 8'h46;
      8'h02:   table_byte = 8'h44;
      8'h03:   table_byte = 8'h50;
      default: table_byte = ~idx;
    endcase
  endfunction

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {cs_q1, cs_q2, cs_q3} <= 3'b111;
      {sck_q1, sck_q2, sck_q3, si_q1, si_q2} <= 5'b0;
    end else if (i_clock_en) begin
      cs_q1  <= spi.cs_n;
      cs_q2  <= cs_q1;
      cs_q3  <= cs_q2;
      sck_q1 <= spi.sck;
      sck_q2 <= sck_q1;
      sck_q3 <= sck_q2;
      si_q1  <= spi.mosi;
      si_q2  <= si_q1;
    end
  end

  assign sck_rise = sck_q2 && !sck_q3 && !cs_q2;
  assign sck_fall = !sck_q2 && sck_q3 && !cs_q2;
  assign cs_rise  = cs_q2 && !cs_q3;

  always_comb begin
    addr_end = OPCODE_BITS + ADDR3_BITS;
    if (i_four_byte_mode && (opcode == OP_SEC_ERASE || opcode == OP_SEC_PROGRAM
                             || opcode == OP_SEC_READ)) begin
      addr_end = OPCODE_BITS + ADDR4_BITS;
    end
    case (opcode)
      OP_DEVICE_ID, OP_READ_STATUS: data_start = OPCODE_BITS;
      OP_UNIQUE_ID:   data_start = OPCODE_BITS + (i_four_byte_mode ? UID_DUMMY4_BITS
                                                     : UID_DUMMY3_BITS);
      OP_PARAM_TABLE: data_start = TABLE_START;
      OP_SEC_READ:    data_start = addr_end + DUMMY_BITS;
      default:        data_start = NO_DATA;
    endcase
  end

  assign next_addr = {shifter[30:0], si_q2};
  assign sel_ok    = sec_valid(addr, i_security_lock_bits);
  assign sel_idx   = addr[13:12] - 2'd1;

  // Outgoing byte for the current position of the data phase
  always_comb begin
    case (opcode)
      OP_DEVICE_ID:
        case (byte_idx)
          8'h00:   next_byte = MAKER_BYTE;
          8'h01:   next_byte = MEMORY_TYPE;
          8'h02:   next_byte = CAPACITY_BYTE;
          default: next_byte = 8'h00;
        endcase
      OP_UNIQUE_ID:
        next_byte = (byte_idx < 8'h08) ? UNIQUE_ID[8'd63 - {byte_idx[4:0], 3'b000} -: 8]
                                        : 8'h00;
      OP_PARAM_TABLE: next_byte = table_byte(addr[7:0] + byte_idx);
      OP_SEC_READ:    next_byte = sec_valid(addr, 3'b000)
                                  ? sec_mem[{sel_idx, addr[7:0] + byte_idx}]
                                  : 8'h00;
      OP_READ_STATUS: next_byte = {6'b0, o_write_enable_latch, o_busy};
      default:        next_byte = 8'h00;
    endcase
  end

  // Inbound shifting on link rising edges
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      bitcnt  <= 16'h0000;
      shifter <= 32'h0;
      opcode  <= 8'h00;
      addr    <= 32'h0;
      cmd_ok  <= 1'b0;
    end else if (i_clock_en) begin
      if (cs_q2 && cs_q3) begin
        bitcnt <= 16'h0000;
        cmd_ok <= 1'b0;
      end else if (sck_rise) begin
        if (bitcnt != 16'hffff) begin
          bitcnt <= bitcnt + 16'h0001;
        end
        shifter <= next_addr;
        if (bitcnt == OPCODE_BITS - 16'h0001) begin
          opcode <= next_addr[7:0];
          // Only status reads get through while an internal cycle runs
          cmd_ok <= !o_busy || next_addr[7:0] == OP_READ_STATUS;
          addr   <= 32'h0;
        end
        if (bitcnt == addr_end - 16'h0001) begin
          addr <= (addr_end == OPCODE_BITS + ADDR3_BITS) ? {8'h00, next_addr[23:0]}
                                                         : next_addr;
        end
      end
    end
  end

  // Outbound data on link falling edges, stream runs until select rises
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      out_sr      <= 8'h00;
      byte_idx    <= 8'h00;
      spi.miso    <= 1'b0;
      spi.miso_oe <= 1'b0;
    end else if (i_clock_en) begin
      if (cs_q2) begin
        byte_idx    <= 8'h00;
        spi.miso_oe <= 1'b0;
      end else if (sck_fall && cmd_ok && bitcnt >= data_start) begin
        spi.miso_oe <= 1'b1;
        if (bitcnt[2:0] == data_start[2:0]) begin
          spi.miso <= next_byte[7];
          out_sr   <= {next_byte[6:0], 1'b0};
          byte_idx <= byte_idx + 8'h01;
        end else begin
          spi.miso <= out_sr[7];
          out_sr   <= {out_sr[6:0], 1'b0};
        end
      end
    end
  end

  // A data byte completes on the rising edge that brings its eighth bit
  assign wr_byte = sck_rise && cmd_ok && opcode == OP_SEC_PROGRAM && bitcnt >= addr_end
                && bitcnt[2:0] == 3'd7 && o_write_enable_latch && sel_ok;
  assign erase_go = cs_rise && cmd_ok && opcode == OP_SEC_ERASE && bitcnt == addr_end
                 && o_write_enable_latch && sel_ok;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prog_ptr   <= 8'h00;
      prog_wrote <= 1'b0;
    end else if (i_clock_en) begin
      if (cs_q2) begin
        prog_wrote <= 1'b0;
      end else if (sck_rise && bitcnt == addr_end - 16'h0001) begin
        prog_ptr <= next_addr[7:0];
      end else if (wr_byte) begin
        prog_ptr   <= prog_ptr + 8'h01;
        prog_wrote <= 1'b1;
      end
    end
  end

  // Programming only clears bits; erase sweeps one byte per clock
  always_ff @(posedge i_clock) begin
    if (i_clock_en) begin
      if (wr_byte) begin
        sec_mem[{sel_idx, prog_ptr}] <= sec_mem[{sel_idx, prog_ptr}] & next_addr[7:0];
      end else if (erasing && cycle_cnt < 32'd256) begin
        sec_mem[{target, cycle_cnt[7:0]}] <= ERASED_BYTE;
      end
    end
  end

  // Self-timed cycle, busy flag and write enable latch
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_busy               <= 1'b0;
      o_write_enable_latch <= 1'b0;
      erasing              <= 1'b0;
      target               <= 2'b00;
      cycle_cnt            <= 32'd0;
    end else if (i_clock_en) begin
      if (o_busy) begin
        cycle_cnt <= cycle_cnt + 32'd1;
        if (cycle_cnt == (erasing ? ERASE_CYCLES : PROGRAM_CYCLES) - 1) begin
          o_busy               <= 1'b0;
          erasing              <= 1'b0;
          o_write_enable_latch <= 1'b0;
        end
      end else if (erase_go) begin
        o_busy    <= 1'b1;
        erasing   <= 1'b1;
        target    <= sel_idx;
        cycle_cnt <= 32'd0;
      end else if (cs_rise && prog_wrote) begin
        o_busy    <= 1'b1;
        cycle_cnt <= 32'd0;
      end else if (cs_rise && cmd_ok && bitcnt == OPCODE_BITS) begin
        if (opcode == OP_WRITE_ENABLE) begin
          o_write_enable_latch <= 1'b1;
        end else if (opcode == OP_WRITE_DISABLE) begin
          o_write_enable_latch <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/fsr_host.sv ***
// Host end: byte-wide serial engine commanded over APB.
// Assumes software sequences opcodes, addresses, dummies and select.
`default_nettype none
module fsr_host
  import fsr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clock_en,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Link
  fsr_spi_if.host          spi
);
  fsr_link_state_t state;
  logic [7:0]  half_period;
  logic        cs_active;
  logic [7:0]  tx_sr, rx_sr, rx_byte;
  logic [7:0]  half_cnt;
  logic [2:0]  bit_idx;
  logic        so_q1, so_q2;
  logic        setup, wr_data, wr_ctrl;

  function automatic logic [7:0] clamp_half(input logic [7:0] v);
    clamp_half = (v < HALF_PERIOD_MIN) ? HALF_PERIOD_MIN : v;
  endfunction

  // Zero-wait slave: ready rises in the first access cycle
  assign setup   = i_psel && !i_penable;
  assign wr_data = i_psel && i_penable && o_pready && i_pwrite && i_paddr == REG_DATA;
  assign wr_ctrl = i_psel && i_penable && o_pready && i_pwrite && i_paddr == REG_CTRL;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else if (i_clock_en) begin
      o_pready  <= setup;
      o_pslverr <= setup && i_paddr != REG_CTRL && i_paddr != REG_DATA
                         && i_paddr != REG_STATUS;
      if (setup && !i_pwrite) begin
        case (i_paddr)
          REG_CTRL:   o_prdata <= {16'h0, half_period, 7'h0, cs_active};
          REG_DATA:   o_prdata <= {24'h0, rx_byte};
          REG_STATUS: o_prdata <= {31'h0, state != FSR_IDLE};
          default:    o_prdata <= 32'h0;
        endcase
      end
    end
  end

  // Select moves only between bytes, so a frame always ends on a whole byte
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cs_active   <= 1'b0;
      half_period <= HALF_PERIOD_RESET;
      spi.cs_n    <= 1'b1;
    end else if (i_clock_en) begin
      if (wr_ctrl && state == FSR_IDLE) begin
        cs_active   <= i_pwdata[CTRL_CS_BIT];
        half_period <= clamp_half(i_pwdata[CTRL_DIV_LSB +: 8]);
        spi.cs_n    <= !i_pwdata[CTRL_CS_BIT];
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      so_q1 <= 1'b1;
      so_q2 <= 1'b1;
    end else if (i_clock_en) begin
      so_q1 <= spi.miso_line;
      so_q2 <= so_q1;
    end
  end

  // Clock divider and shifter: out on falling, sample just before rising
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state    <= FSR_IDLE;
      spi.sck  <= 1'b0;
      spi.mosi <= 1'b0;
      tx_sr    <= 8'h00;
      rx_sr    <= 8'h00;
      rx_byte  <= 8'h00;
      half_cnt <= 8'h00;
      bit_idx  <= 3'd0;
    end else if (i_clock_en) begin
      case (state)
        FSR_IDLE: begin
          if (wr_data && cs_active) begin
            spi.mosi <= i_pwdata[7];
            tx_sr    <= {i_pwdata[6:0], 1'b0};
            half_cnt <= half_period - 8'h01;
            bit_idx  <= 3'd0;
            state    <= FSR_LOW;
          end
        end
        FSR_LOW: begin
          if (half_cnt == 8'h00) begin
            spi.sck  <= 1'b1;
            rx_sr    <= {rx_sr[6:0], so_q2};
            half_cnt <= half_period - 8'h01;
            state    <= FSR_HIGH;
          end else begin
            half_cnt <= half_cnt - 8'h01;
          end
        end
        FSR_HIGH: begin
          if (half_cnt == 8'h00) begin
            spi.sck  <= 1'b0;
            half_cnt <= half_period - 8'h01;
            if (bit_idx == 3'd7) begin
              rx_byte <= rx_sr;
              state   <= FSR_IDLE;
            end else begin
              spi.mosi <= tx_sr[7];
              tx_sr    <= {tx_sr[6:0], 1'b0};
              bit_idx  <= bit_idx + 3'd1;
              state    <= FSR_LOW;
            end
          end else begin
            half_cnt <= half_cnt - 8'h01;
          end
        end
        default: state <= FSR_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** test/fsr_checker.sv ***
// Link-level checker for the flash device end and its host controller.
// Assumes one 40 MHz clock domain for both ends and a synchronous reset.
`default_nettype none
module fsr_checker #(
  parameter int ERASE_CYCLES   = 300,
  parameter int PROGRAM_CYCLES = 8
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_clock_en,
  // Link
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic miso_line,
  // Device status
  input  wire logic o_busy,
  input  wire logic o_write_enable_latch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] busy_len;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // Length of the internal cycle that has just ended
  always_ff @(posedge i_clock) begin
    if (i_rst || !o_busy) begin
      busy_len <= 16'h0000;
    end else if (i_clock_en) begin
      busy_len <= busy_len + 16'h0001;
    end
  end

  idle_clock_low_a: assert property (cs_n |-> !sck)
    else $error("link clock moves while deselected");
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
    else $error("device keeps driving after deselect");
  oe_deselected_a: assert property (cs_n [*6] |-> !miso_oe)
    else $error("device drives while deselected");
  bit_stable_a: assert property ((miso_oe && sck && $past(sck)) |-> $stable(miso))
    else $error("data bit changes while link clock high");
  busy_needs_latch_a: assert property ($rose(o_busy) |-> $past(o_write_enable_latch))
    else $error("internal cycle started without write enable");
  busy_after_select_a: assert property ($rose(o_busy) |-> cs_n)
    else $error("internal cycle started inside a frame");
  latch_cleared_a: assert property ($fell(o_busy) |-> ##[0:2] !o_write_enable_latch)
    else $error("write enable survives a finished cycle");
  busy_length_a: assert property ($fell(o_busy) |->
    (busy_len >= PROGRAM_CYCLES - 2 && busy_len <= ERASE_CYCLES + 4))
    else $error("internal cycle length out of range");
  latch_not_busy_a: assert property ($rose(o_write_enable_latch) |-> (cs_n && !o_busy))
    else $error("write enable set while busy or selected");
  mosi_stable_a: assert property ((!cs_n && sck && $past(sck)) |-> $stable(mosi))
    else $error("host data bit changes while link clock high");
  line_idle_a: assert property (!miso_oe |-> miso_line)
    else $error("undriven data line not at idle level");

  cover property ($fell(o_busy));
  cover property ($rose(miso_oe));
  cover property ($rose(o_write_enable_latch));
endmodule
`default_nettype wire

// *** test/fsr_tb.sv ***
// Bench joining host and device ends over the link, driven through APB.
// Assumes host registers as in the package and an array model of memory.
`default_nettype none
module fsr_tb
  import fsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] UID   = 64'h0123_4567_89ab_cdef; // Arbitrary value
  localparam logic [7:0]  MAKER = 8'h5c;                   // Arbitrary value
  localparam int          ERASE_N = 300;
  localparam int          PROG_N  = 8;

  logic        i_clock, i_rst, psel, penable, pwrite, four_mode, err_seen, o_pready;
  logic        o_pslverr, o_busy, o_wel, clk_en;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, o_prdata;
  logic [2:0]  lock_bits;
  logic [63:0] v;
  logic [7:0]  txq[$], rxq[$];
  logic [7:0]  mem [0:767];
  int          error_cnt, comparisons, seed;

  fsr_spi_if spi_bus ();
  fsr_host fsr_host_inst (.i_clock(i_clock), .i_rst(i_rst), .i_clock_en(clk_en),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .spi(spi_bus));
  fsr_device #(.UNIQUE_ID(UID), .MAKER_BYTE(MAKER), .ERASE_CYCLES(ERASE_N),
    .PROGRAM_CYCLES(PROG_N))
    fsr_device_inst (.i_clock(i_clock), .i_rst(i_rst), .i_clock_en(clk_en), .spi(spi_bus),
    .i_four_byte_mode(four_mode), .i_security_lock_bits(lock_bits),
    .o_busy(o_busy), .o_write_enable_latch(o_wel));
  // Checker defaults equal the bench's cycle counts
  fsr_checker fsr_checker_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_clock_en(clk_en), .cs_n(spi_bus.cs_n),
    .sck(spi_bus.sck),
    .mosi(spi_bus.mosi), .miso(spi_bus.miso), .miso_oe(spi_bus.miso_oe),
    .miso_line(spi_bus.miso_line), .o_busy(o_busy), .o_write_enable_latch(o_wel));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk(64'h0, 64'h1);
      print_verdict;
    end
    prdata = o_prdata;
    err_seen = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One byte each way; the engine must be idle before the next byte goes
  task automatic xfer(input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, REG_DATA, {24'h0, d});
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (prdata[0] !== 1'b0 && n < 200);
    if (n >= 200) begin
      chk(64'h0, 64'h1);
      print_verdict;
    end
    apb(1'b0, REG_DATA, 32'h0);
  endtask

  // Half period 6 keeps frames short yet meets the device's sampling latency
  task automatic frame(input int nrx);
    apb(1'b1, REG_CTRL, 32'h0000_0601);
    foreach (txq[i]) xfer(txq[i]);
    rxq = {};
    repeat (nrx) begin
      xfer(8'h00);
      rxq.push_back(prdata[7:0]);
    end
    apb(1'b1, REG_CTRL, 32'h0000_0600);
    repeat (4) @(posedge i_clock);
  endtask

  task automatic cmd(input logic [7:0] op);
    txq = {op};
    frame(0);
  endtask

  task automatic sec_cmd(input logic [7:0] op, input logic [7:0] mid, input logic [7:0] a);
    txq = {op};
    if (four_mode) txq.push_back(8'h00);
    txq.push_back(8'h00);
    txq.push_back(mid);
    txq.push_back(a);
  endtask

  task automatic poll_idle;
    int n;
    n = 0;
    do begin
      txq = {OP_READ_STATUS};
      frame(1);
      n++;
    end while (rxq[0][0] !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk(64'h0, 64'h1);
      print_verdict;
    end
  endtask

  task automatic check_read(input int r, input logic [7:0] a, input int nb, input logic ign);
    sec_cmd(OP_SEC_READ, {4'(r + 1), 4'h0}, a);
    txq.push_back(8'h00);
    frame(nb);
    foreach (rxq[k]) chk(rxq[k], ign ? 8'hff : mem[r * 256 + (int'(a) + k) % 256]);
  endtask

  task automatic model_erase(input int r);
    for (int k = 0; k < 256; k++) mem[r * 256 + k] = ERASED_BYTE;
  endtask

  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    seed = 37; error_cnt = 0; comparisons = 0; i_rst = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    four_mode = 1'b0; lock_bits = 3'b000;
    clk_en = 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    apb(1'b0, 8'h0c, 32'h0);
    chk({err_seen, prdata}, {1'b1, 32'h0});
    txq = {OP_DEVICE_ID};
    frame(4);
    chk({rxq[0], rxq[1], rxq[2], rxq[3]}, {MAKER, 8'h40, 8'h20, 8'h00});
    for (int m = 0; m < 2; m++) begin
      four_mode <= m[0];
      @(posedge i_clock);
      txq = {OP_UNIQUE_ID};
      repeat (4 + m) txq.push_back(8'h00);
      frame(8);
      foreach (rxq[k]) v = {v[55:0], rxq[k]};
      chk(v, UID);
    end
    // Table read keeps three address bytes in four-byte mode and wraps
    txq = {OP_PARAM_TABLE, 8'h00, 8'h00, 8'hfe, 8'h00};
    frame(4);
    chk({rxq[0], rxq[1], rxq[2], rxq[3]}, 32'h0100_5346);
    four_mode <= 1'b0;
    cmd(OP_WRITE_ENABLE);
    sec_cmd(OP_SEC_ERASE, 8'h10, 8'h00);
    frame(0);
    model_erase(0);
    // Clock enable low freezes the erase, so busy outlasts its own length
    clk_en <= 1'b0;
    repeat (ERASE_N + 50) @(posedge i_clock);
    clk_en <= 1'b1;
    chk(o_busy, 1'b1);
    txq = {OP_READ_STATUS};
    frame(1);
    chk(rxq[0], 8'h03);
    poll_idle;
    chk(o_wel, 1'b0);
    cmd(OP_WRITE_ENABLE);
    sec_cmd(OP_SEC_PROGRAM, 8'h10, 8'hfe);
    for (int k = 0; k < 4; k++) begin
      b = 8'($random(seed));
      txq.push_back(b);
      mem[(254 + k) % 256] = b;
    end
    frame(0);
    poll_idle;
    check_read(0, 8'hfe, 6, 1'b0);
    four_mode <= 1'b1;
    @(posedge i_clock);
    check_read(0, 8'hff, 3, 1'b0);
    four_mode <= 1'b0;
    // Register two erased while register one is read: the read is ignored
    cmd(OP_WRITE_ENABLE);
    sec_cmd(OP_SEC_ERASE, 8'h20, 8'h00);
    frame(0);
    model_erase(1);
    check_read(0, 8'hfe, 2, 1'b1);
    poll_idle;
    check_read(1, 8'h00, 2, 1'b0);
    check_read(0, 8'hfe, 2, 1'b0);
    // No latch, locked, bad select, extra byte, program without latch, locked program
    for (int c = 0; c < 6; c++) begin
      lock_bits <= (c == 1 || c == 5) ? 3'b001 : 3'b000;
      if (c != 0 && c != 4) cmd(OP_WRITE_ENABLE);
      sec_cmd(c >= 4 ? OP_SEC_PROGRAM : OP_SEC_ERASE, c == 2 ? 8'h11 : 8'h10, 8'hfe);
      if (c >= 3) txq.push_back(8'h00);
      frame(0);
      repeat (8) @(posedge i_clock);
      chk(o_busy, 1'b0);
      check_read(0, 8'hfe, 1, 1'b0);
      cmd(OP_WRITE_DISABLE);
    end
    lock_bits <= 3'b000;
    print_verdict;
  end
endmodule
`default_nettype wire
